/* File: hw/cils_pkg.sv */
// Purpose: shared constants and types of the configuration loader
// Assumes: three switch ports, six loadable configuration words per port
// Notes:   register index doubles as the management-bus command code
package cils_pkg;
  localparam int         PORTS    = 3;
  localparam int         NREG     = 6;
  // register index per port, carried in command byte bits 2:0
  localparam logic [2:0] RI_ACKRTO = 3'h0; // offset 70h
  localparam logic [2:0] RI_PHY3   = 3'h1; // offset 80h
  localparam logic [2:0] RI_TSC    = 3'h2; // offset 8Ch
  localparam logic [2:0] RI_SLOT   = 3'h3; // offset D4h
  localparam logic [2:0] RI_VC1    = 3'h4; // offset 15Ch
  localparam logic [2:0] RI_TCMAP  = 3'h5; // offset 160h
  localparam logic [31:0] REG_RST  = 32'h0000_0000;
  // fixed upper bits 6:3 of the slave address
  localparam logic [3:0] SLV_HI    = 4'hD;
  // eeprom word addresses
  localparam logic [7:0] EE_SLOT_LO_P2 = 8'h94;
  localparam logic [7:0] EE_SLOT_HI_P1 = 8'hA2;
  localparam logic [7:0] EE_SLOT_HI_P2 = 8'hA4;
  localparam logic [3:0] EE_PHY3_LO    = 4'hB;
  localparam logic [3:0] EE_PHY3_HI    = 4'hC;
  localparam logic [3:0] EE_RTO        = 4'hD;
  localparam logic [3:0] EE_ACKLAT     = 4'hE;
  localparam logic [3:0] EE_VC1        = 4'hF;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_CMD, ST_WDATA, ST_RDATA, ST_SKIP
  } cils_state_t;

  typedef struct packed {
    logic [2:0]            scl_sy;
    logic [2:0]            sda_sy;
    logic [2:0][2:0]       strap_sy;
    logic                  scl_f;
    logic                  sda_f;
    logic [2:0]            strap;
    cils_state_t           st;
    logic                  in_ack;
    logic [7:0]            sh;
    logic [3:0]            bcnt;
    logic [1:0]            bidx;
    logic [1:0]            port;
    logic [2:0]            ridx;
    logic [31:0]           wbuf;
    logic [31:0]           rbuf;
    logic                  sda_oe;
    logic                  scl_oe;
    logic [2:0][5:0][31:0] regs;
  } cils_q_t;

  // bits that exist in each loadable word
  function automatic logic [31:0] cils_wmask(input logic [2:0] ri);
    case (ri)
      RI_ACKRTO: cils_wmask = 32'h7FFF_1FFF;
      RI_PHY3:   cils_wmask = 32'hFFFF_FFFF;
      RI_TSC:    cils_wmask = 32'h0300_0000;
      RI_SLOT:   cils_wmask = 32'hFFFF_FFFF;
      RI_VC1:    cils_wmask = 32'h007F_0000;
      RI_TCMAP:  cils_wmask = 32'h0000_00FF;
      default:   cils_wmask = 32'h0000_0000;
    endcase
  endfunction : cils_wmask
endpackage : cils_pkg

/* File: hw/cils_loader.sv */
// Purpose: eeprom autoload of per-port config words plus smbus slave access
// Assumes: eeprom words arrive already fetched, on mclk_in, one per strobe
// Notes:   command byte = {port[1:0], 3'b0, reg index[2:0]}, 4 data bytes
//
// Operation
// - eeprom word 94h loads bits 15:0 of port 2 slot capability (D4h).
// - eeprom words A2h and A4h load bits 31:16 of D4h of ports 1 and 2.
// - words B0h, B2h, B4h load bits 15:0 of 80h of ports 0, 1, 2.
// - words C0h, C2h, C4h load bits 31:16 of 80h of ports 0, 1, 2.
// - bits 12:0 of words D0h-D4h load the replay time-out at 70h.
// - bits 14:13 of words D0h-D4h load bits 25:24 of 8Ch.
// - words E0h-E4h load the ack latency timer, bits 30:16 of 70h.
// - bits 6:0 of words F0h-F4h load bits 22:16 of 15Ch.
// - bits 15:8 of words F0h-F4h load the tc map, bits 7:0 of 160h.
// - the block is only a slave: it takes written data, returns reads.
// - every read/write config word is readable and writable by smbus.
// - autoloadable read-only words are also smbus writable.
// - only the strap-derived slave address is answered.
// - address bits 2:0 come from straps, bits 6:3 are 1,1,0,1.
// - clock and data lines are open lines, both sensed; only data is driven.
`timescale 1ns/1ps
`default_nettype none
module cils_loader
  import cils_pkg::*;
(
  // clock and reset
  input  wire logic                  mclk_in,
  input  wire logic                  rstn_in,
  // eeprom word stream
  input  wire logic                  ee_valid_in,
  input  wire logic [7:0]            ee_addr_in,
  input  wire logic [15:0]           ee_data_in,
  // address straps, general pins 7:5
  input  wire logic [2:0]            strap_in,
  // management bus pins
  input  wire logic                  mgmt_bus_clock_pin_in,
  output logic                       mgmt_bus_clock_pin_out,
  output logic                       mgmt_bus_clock_pin_oe_out,
  input  wire logic                  mgmt_bus_data_pin_in,
  output logic                       mgmt_bus_data_pin_out,
  output logic                       mgmt_bus_data_pin_oe_out,
  // configuration words [port][index]
  output logic [2:0][5:0][31:0]      cfg_out
);
  cils_q_t q;
  cils_q_t d;
  logic    scl_rise, scl_fall, sda_rise, sda_fall, start_ev, stop_ev;
  logic    commit, addr_hit, byte_in;
  logic [1:0] ee_p;
  logic [7:0] rbyte;

  always_comb begin
    d = q;
    // three stage synchronisers, change taken once stages 2 and 3 agree
    d.scl_sy   = {q.scl_sy[1:0], mgmt_bus_clock_pin_in};
    d.sda_sy   = {q.sda_sy[1:0], mgmt_bus_data_pin_in};
    d.strap_sy = {q.strap_sy[1:0], strap_in};
    if (q.scl_sy[1] == q.scl_sy[2]) d.scl_f = q.scl_sy[2];
    if (q.sda_sy[1] == q.sda_sy[2]) d.sda_f = q.sda_sy[2];
    if (q.strap_sy[1] == q.strap_sy[2]) d.strap = q.strap_sy[2];
    scl_rise = d.scl_f & ~q.scl_f;
    scl_fall = ~d.scl_f & q.scl_f;
    sda_rise = d.sda_f & ~q.sda_f;
    sda_fall = ~d.sda_f & q.sda_f;
    start_ev = sda_fall & q.scl_f & d.scl_f;
    stop_ev  = sda_rise & q.scl_f & d.scl_f;
    byte_in  = scl_fall & ~q.in_ack & (q.bcnt == BITS_PER_BYTE);
    addr_hit = (q.sh[7:1] == {SLV_HI, q.strap});
    commit   = 1'b0;
    ee_p     = ee_addr_in[2:1];
    rbyte    = q.rbuf[8*q.bidx +: 8];

    // autoload; a same-cycle smbus write below takes precedence
    if (ee_valid_in && !ee_addr_in[0] && !ee_addr_in[3] && ee_p != 2'h3) begin
      case (ee_addr_in[7:4])
        EE_PHY3_LO: d.regs[ee_p][RI_PHY3][15:0] = ee_data_in;
        EE_PHY3_HI: d.regs[ee_p][RI_PHY3][31:16] = ee_data_in;
        EE_RTO: begin
          d.regs[ee_p][RI_ACKRTO][12:0] = ee_data_in[12:0];
          d.regs[ee_p][RI_TSC][25:24] = ee_data_in[14:13];
        end
        EE_ACKLAT: d.regs[ee_p][RI_ACKRTO][30:16] = ee_data_in[14:0];
        EE_VC1: begin
          d.regs[ee_p][RI_VC1][22:16] = ee_data_in[6:0];
          d.regs[ee_p][RI_TCMAP][7:0] = ee_data_in[15:8];
        end
        default: begin
          case (ee_addr_in)
            EE_SLOT_LO_P2: d.regs[2][RI_SLOT][15:0] = ee_data_in;
            EE_SLOT_HI_P1: d.regs[1][RI_SLOT][31:16] = ee_data_in;
            EE_SLOT_HI_P2: d.regs[2][RI_SLOT][31:16] = ee_data_in;
            default: ;
          endcase
        end
      endcase
    end

    // smbus slave; start and stop override any clock edge handling
    if (start_ev) begin
      d.st     = ST_ADDR;
      d.bcnt   = 4'h0;
      d.in_ack = 1'b0;
      d.sda_oe = 1'b0;
    end else if (stop_ev) begin
      d.st     = ST_IDLE;
      d.in_ack = 1'b0;
      d.sda_oe = 1'b0;
    end else if (scl_rise) begin
      if (q.in_ack) begin
        // our own ack reads low, so only a master nack ends a read
        if (q.st == ST_RDATA && q.sda_f) d.st = ST_SKIP;
      end else if (q.st == ST_ADDR || q.st == ST_CMD || q.st == ST_WDATA) begin
        d.sh   = {q.sh[6:0], q.sda_f};
        d.bcnt = q.bcnt + 4'h1;
      end
    end else if (scl_fall && q.in_ack) begin
      d.in_ack = 1'b0;
      d.sda_oe = 1'b0;
      d.bcnt   = 4'h0;
      if (q.st == ST_RDATA) begin
        // first bit of the next read byte goes out on this fall
        d.sda_oe = ~rbyte[7];
        d.sh     = {rbyte[6:0], 1'b0};
        d.bcnt   = 4'h1;
        d.bidx   = q.bidx + 2'h1;
      end
    end else if (scl_fall && q.st == ST_RDATA) begin
      if (q.bcnt == BITS_PER_BYTE) begin
        d.sda_oe = 1'b0;
        d.in_ack = 1'b1;
      end else begin
        d.sda_oe = ~q.sh[7];
        d.sh     = {q.sh[6:0], 1'b0};
        d.bcnt   = q.bcnt + 4'h1;
      end
    end else if (byte_in) begin
      d.bcnt = 4'h0;
      case (q.st)
        ST_ADDR: begin
          if (addr_hit) begin
            d.sda_oe = 1'b1;
            d.in_ack = 1'b1;
            d.bidx   = 2'h0;
            d.rbuf   = q.regs[q.port][q.ridx];
            d.st     = q.sh[0] ? ST_RDATA : ST_CMD;
          end else begin
            d.st = ST_SKIP;
          end
        end
        ST_CMD: begin
          if (q.sh[7:6] != 2'h3 && q.sh[2:0] < 3'(NREG)) begin
            d.port   = q.sh[7:6];
            d.ridx   = q.sh[2:0];
            d.bidx   = 2'h0;
            d.sda_oe = 1'b1;
            d.in_ack = 1'b1;
            d.st     = ST_WDATA;
          end else begin
            d.st = ST_SKIP;
          end
        end
        ST_WDATA: begin
          d.wbuf[8*q.bidx +: 8] = q.sh;
          d.bidx   = q.bidx + 2'h1;
          d.sda_oe = 1'b1;
          d.in_ack = 1'b1;
          if (q.bidx == 2'h3) begin
            // read-only fields are writable here too
            commit = 1'b1;
            d.regs[q.port][q.ridx] = {q.sh, q.wbuf[23:0]} &
                                     cils_wmask(q.ridx);
          end
        end
        default: ;
      endcase
    end
    // the slave never stretches the clock line
    d.scl_oe = 1'b0;
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      q          <= '0;
      q.scl_sy   <= 3'h7;
      q.sda_sy   <= 3'h7;
      q.scl_f    <= 1'b1;
      q.sda_f    <= 1'b1;
      q.st       <= ST_IDLE;
      q.regs     <= {(PORTS*NREG){REG_RST}};
    end else begin
      q <= d;
    end
  end

  assign mgmt_bus_clock_pin_out    = q.scl_oe & 1'b0;
  assign mgmt_bus_clock_pin_oe_out = q.scl_oe;
  assign mgmt_bus_data_pin_out     = q.sda_oe & 1'b0;
  assign mgmt_bus_data_pin_oe_out  = q.sda_oe;
  assign cfg_out                   = q.regs;

  // checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  a_foreign_addr: assert property (byte_in && q.st == ST_ADDR && !addr_hit
    |=> q.st == ST_SKIP && !q.sda_oe)
    else $error("foreign address answered");
  a_own_addr_ack: assert property (byte_in && q.st == ST_ADDR && addr_hit
    |=> q.sda_oe && q.in_ack ##1 q.sda_oe)
    else $error("own address not acknowledged");
  a_addr_pattern: assert property (byte_in && q.st == ST_ADDR && addr_hit
    |-> q.sh[7:4] == 4'hD && q.sh[3:1] == q.strap)
    else $error("slave address pattern wrong");
  a_slot_lo_load: assert property (ee_valid_in && ee_addr_in == 8'h94
    && !commit |=> q.regs[2][3][15:0] == $past(ee_data_in))
    else $error("slot low word not loaded");
  a_rto_tsc_load: assert property (ee_valid_in && ee_addr_in == 8'hD2
    && !commit |=> q.regs[1][0][12:0] == $past(ee_data_in[12:0])
    && q.regs[1][2][25:24] == $past(ee_data_in[14:13]))
    else $error("replay or ts counter field not loaded");
  a_tcmap_load: assert property (ee_valid_in && ee_addr_in == 8'hF4
    && !commit |=> q.regs[2][5][7:0] == $past(ee_data_in[15:8])
    && q.regs[2][4][22:16] == $past(ee_data_in[6:0]))
    else $error("vc1 fields not loaded");
  a_ack_lat_load: assert property (ee_valid_in && ee_addr_in == 8'hE0
    && !commit |=> q.regs[0][0][30:16] == $past(ee_data_in[14:0]))
    else $error("ack latency not loaded");
  a_commit_write: assert property (commit |=> q.regs[$past(q.port)]
    [$past(q.ridx)] == ({$past(q.sh), $past(q.wbuf[23:0])}
    & cils_wmask($past(q.ridx))))
    else $error("smbus write not stored");
  a_idle_quiet: assert property (q.st == ST_IDLE |-> !q.sda_oe
    && !q.scl_oe)
    else $error("line driven while idle");

  c_write: cover property (commit);
  c_read_nack: cover property (q.st == ST_RDATA ##[1:400] q.st == ST_SKIP);
  c_foreign: cover property (byte_in && q.st == ST_ADDR && !addr_hit);
  c_autoload: cover property (ee_valid_in && ee_addr_in == 8'hA4);
endmodule : cils_loader
`default_nettype wire

/* File: dv/cils_smb_master.sv */
// Purpose: smbus master model on open lines with pull-ups
// Assumes: a quarter bit lasts Q core clocks, data sampled while clock high
// Notes:   the slave never stretches, so the clock line is not re-sensed
`timescale 1ns/1ps
`default_nettype none
module cils_smb_master #(
  parameter int Q = 8
) (
  input  wire logic mclk_in,
  input  wire logic scl_oe_in,
  input  wire logic sda_oe_in,
  output logic      scl_out,
  output logic      sda_out
);
  logic scl_m = 1'b1;
  logic sda_m = 1'b1;
  // wired and: a released line floats to the pull-up level
  assign scl_out = scl_m & ~scl_oe_in;
  assign sda_out = sda_m & ~sda_oe_in;

  task automatic qw();
    repeat (Q) @(negedge mclk_in);
  endtask : qw

  // also serves as repeated start while the clock is low
  task automatic start();
    sda_m = 1'b1;
    qw();
    scl_m = 1'b1;
    qw();
    sda_m = 1'b0;
    qw();
    scl_m = 1'b0;
    qw();
  endtask : start

  task automatic stop();
    sda_m = 1'b0;
    qw();
    scl_m = 1'b1;
    qw();
    sda_m = 1'b1;
    qw();
  endtask : stop

  // nine bits: eight data msb first, then the acknowledge slot
  task automatic xbyte(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      sda_m = d[i];
      qw();
      scl_m = 1'b1;
      qw();
      r[i] = sda_out;
      qw();
      scl_m = 1'b0;
      qw();
    end
  endtask : xbyte

  // command byte then four data bytes, least significant byte first
  task automatic wr(input logic [6:0] a, input logic [7:0] c,
                    input logic [31:0] w, output logic [5:0] nak);
    logic [8:0] r;
    start();
    xbyte({a, 2'b01}, r);
    nak[0] = r[0];
    xbyte({c, 1'b1}, r);
    nak[1] = r[0];
    for (int k = 0; k < 4; k++) begin
      xbyte({w[8*k+:8], 1'b1}, r);
      nak[k+2] = r[0];
    end
    stop();
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic [7:0] c,
                    output logic [31:0] w, output logic [2:0] nak);
    logic [8:0] r;
    start();
    xbyte({a, 2'b01}, r);
    nak[0] = r[0];
    xbyte({c, 1'b1}, r);
    nak[1] = r[0];
    start();
    xbyte({a, 2'b11}, r);
    nak[2] = r[0];
    for (int k = 0; k < 4; k++) begin
      xbyte({8'hFF, k == 3}, r);
      w[8*k+:8] = r[8:1];
    end
    stop();
  endtask : rd
endmodule : cils_smb_master
`default_nettype wire

/* File: dv/config_image_load_smbus_access_tb.sv */
// Purpose: self-checking bench of eeprom autoload and smbus access
// Assumes: bench drives the eeprom word stream, partner is the bus master
// Notes:   data from a fixed seed, bad addresses and commands by hand
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    mismatches++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); \
  end \
end
module config_image_load_smbus_access_tb
  import cils_pkg::*;
;
  logic                  mclk_in = 1'b0;
  logic                  rstn_in = 1'b0;
  logic                  ee_valid_in = 1'b0;
  logic [7:0]            ee_addr_in = 8'h00;
  logic [15:0]           ee_data_in = 16'h0000;
  logic [2:0]            strap_in = 3'h0;
  logic                  scl, sda, scl_o, scl_oe, sda_o, sda_oe;
  logic [2:0][5:0][31:0] cfg, exp_cfg;
  logic [31:0]           msk [6] = '{32'h7FFF_1FFF, 32'hFFFF_FFFF,
    32'h0300_0000, 32'hFFFF_FFFF, 32'h007F_0000, 32'h0000_00FF};
  int                    mismatches = 0;
  int                    cmp_count = 0;
  int                    seed = 32'h3946;
  int                    cyc = 0;

  cils_loader dut (.mclk_in(mclk_in), .rstn_in(rstn_in),
    .ee_valid_in(ee_valid_in), .ee_addr_in(ee_addr_in),
    .ee_data_in(ee_data_in), .strap_in(strap_in),
    .mgmt_bus_clock_pin_in(scl), .mgmt_bus_clock_pin_out(scl_o),
    .mgmt_bus_clock_pin_oe_out(scl_oe), .mgmt_bus_data_pin_in(sda),
    .mgmt_bus_data_pin_out(sda_o), .mgmt_bus_data_pin_oe_out(sda_oe),
    .cfg_out(cfg));
  cils_smb_master #(.Q(8)) m (.mclk_in(mclk_in), .scl_oe_in(scl_oe),
    .sda_oe_in(sda_oe), .scl_out(scl), .sda_out(sda));

  always #20 mclk_in = ~mclk_in;

  task automatic wrap_up();
    if (mismatches == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 80000) begin
      mismatches++;
      wrap_up();
    end
  end

  // odd words, port slot 3 and unlisted words leave the image alone
  function automatic void ee_exp(input logic [7:0] a, input logic [15:0] d);
    logic [1:0] p;
    p = a[2:1];
    if (a[3] || a[0] || p == 2'h3) return;
    case (a[7:4])
      4'h9: if (p == 2'h2) exp_cfg[2][3][15:0] = d;
      4'hA: if (p != 2'h0) exp_cfg[p][3][31:16] = d;
      4'hB: exp_cfg[p][1][15:0] = d;
      4'hC: exp_cfg[p][1][31:16] = d;
      4'hD: begin
        exp_cfg[p][0][12:0] = d[12:0];
        exp_cfg[p][2][25:24] = d[14:13];
      end
      4'hE: exp_cfg[p][0][30:16] = d[14:0];
      4'hF: begin
        exp_cfg[p][4][22:16] = d[6:0];
        exp_cfg[p][5][7:0] = d[15:8];
      end
      default: ;
    endcase
  endfunction : ee_exp

  initial begin
    logic [31:0] w, r;
    logic [5:0]  nk;
    logic [2:0]  nr;
    logic [1:0]  p;
    logic [6:0]  sa;
    logic [7:0]  bad [3] = '{8'h06, 8'hC0, 8'h07};
    exp_cfg = '0;
    repeat (6) @(negedge mclk_in);
    rstn_in = 1'b1;
    `CHK("reset", exp_cfg, cfg)
    // back to back over every word address from 90h to FFh, mapped or not
    for (int a = 8'h90; a < 256; a++) begin
      @(negedge mclk_in);
      ee_valid_in = 1'b1;
      ee_addr_in = 8'(a);
      ee_data_in = 16'($random(seed));
      ee_exp(ee_addr_in, ee_data_in);
    end
    @(negedge mclk_in);
    ee_valid_in = 1'b0;
    @(negedge mclk_in);
    `CHK("autoload", exp_cfg, cfg)
    strap_in = 3'($random(seed));
    sa = {4'hD, strap_in};
    repeat (10) @(negedge mclk_in);
    for (int ri = 0; ri < 6; ri++) begin
      p = 2'(($random(seed) & 32'hFF) % 3);
      w = $random(seed);
      m.wr(sa, {p, 3'h0, 3'(ri)}, w, nk);
      `CHK("write acks", 6'h00, nk)
      exp_cfg[p][ri] = w & msk[ri];
      `CHK("written image", exp_cfg, cfg)
      m.rd(sa, {p, 3'h0, 3'(ri)}, r, nr);
      `CHK("read acks", 3'h0, nr)
      `CHK("read word", exp_cfg[p][ri], r)
    end
    // one flipped address bit at a time must be ignored
    for (int b = 0; b < 7; b++) begin
      m.wr(sa ^ 7'(1 << b), 8'h01, $random(seed), nk);
      `CHK("foreign acks", 6'h3F, nk)
    end
    for (int i = 0; i < 3; i++) begin
      m.wr(sa, bad[i], $random(seed), nk);
      `CHK("bad command", 2'h2, nk[1:0])
    end
    `CHK("untouched", exp_cfg, cfg)
    `CHK("idle lines", 4'h0, {scl_o, sda_o, scl_oe, sda_oe})
    wrap_up();
  end
endmodule : config_image_load_smbus_access_tb
`undef CHK
`default_nettype wire
